// File: design/rsse_pkg.sv
// rsse_pkg: constants for the rotate/subtract/halt execution datapath.
// assumes a single 20 MHz core clock and an APB register port with 32-bit data.
package rsse_pkg;

    // register byte offsets
    localparam logic [7:0] RSSE_OFF_CMD    = 8'h00;
    localparam logic [7:0] RSSE_OFF_WREG   = 8'h04;
    localparam logic [7:0] RSSE_OFF_STATUS = 8'h08;
    localparam logic [7:0] RSSE_OFF_WDOG   = 8'h0c;
    localparam logic [7:0] RSSE_OFF_FADDR  = 8'h10;
    localparam logic [7:0] RSSE_OFF_FDATA  = 8'h14;

    // command word layout
    localparam int RSSE_CMD_OP_LSB  = 0;
    localparam int RSSE_CMD_DEST    = 2;
    localparam int RSSE_CMD_FA_LSB  = 8;
    localparam int RSSE_CMD_LIT_LSB = 16;

    // status word layout
    localparam int RSSE_ST_CARRY = 0;
    localparam int RSSE_ST_DC    = 1;
    localparam int RSSE_ST_ZERO  = 2;
    localparam int RSSE_ST_PD    = 3;
    localparam int RSSE_ST_TO    = 4;
    localparam int RSSE_ST_SLEEP = 5;

    // watchdog read word: prescaler low byte, counter next byte
    localparam int RSSE_WD_CNT_LSB = 8;

    // reset values
    localparam logic [7:0] RSSE_W_RST  = 8'h00;
    localparam logic       RSSE_TO_RST = 1'b1;
    localparam logic       RSSE_PD_RST = 1'b1;

    localparam int RSSE_FILE_DEPTH = 128;
    localparam int RSSE_FA_W       = 7;

    typedef enum logic [1:0] {
        RSSE_OP_ROTL  = 2'h0,
        RSSE_OP_ROTR  = 2'h1,
        RSSE_OP_SUB   = 2'h2,
        RSSE_OP_SLEEP = 2'h3
    } rsse_op_t;

    typedef enum logic [3:0] {
        RSSE_IDLE  = 4'b0001,
        RSSE_FETCH = 4'b0010,
        RSSE_EXEC  = 4'b0100,
        RSSE_HALT  = 4'b1000
    } rsse_state_t;

endpackage : rsse_pkg

// File: design/rsse_mem_if.sv
// rsse_mem_if: single port between the execution unit and its file registers.
// assumes both ends share the core clock.
`timescale 1ns/10ps
`default_nettype none
interface rsse_mem_if;
    logic       we;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface : rsse_mem_if
`default_nettype wire

// File: design/rsse_file_ram.sv
// rsse_file_ram: 128 x 8 file register store, read data registered.
// assumes address and write data held stable around the write edge.
`timescale 1ns/10ps
`default_nettype none
module rsse_file_ram
    import rsse_pkg::*;
(
    input  wire logic   i_clock,   // core clock
    input  wire logic   i_resetn,  // async reset, active low
    rsse_mem_if.mem     bus        // port from the execution unit
);
    logic [7:0] store [RSSE_FILE_DEPTH];
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;

    // read-before-write: a read at the write address sees the old byte
    always_comb
    begin
        rdata_d = store[bus.addr];
    end

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            rdata_q <= 8'h00;
        else
            rdata_q <= rdata_d;
    end

    // array has no reset so it can map onto plain ram
    always_ff @(posedge i_clock)
    begin
        if (bus.we)
            store[bus.addr] <= bus.wdata;
    end

    assign bus.rdata = rdata_q;
endmodule : rsse_file_ram
`default_nettype wire

// File: design/rsse_exec.sv
// rsse_exec: executes rotate-through-carry, literal-minus-working and halt.
// assumes an APB master on the core clock and a wake pulse from outside.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - rotate left: carry in bit0, bit7 out
// - rotate right: carry in bit7, bit0 out
// - destination bit picks working or file register
// - halt clears watchdog, prescaler; sets timeout, clears powerdown
// - halt stops oscillator until wake
// - literal minus working; carry when no borrow
// - digit carry clear when low nibble borrows
module rsse_exec
    import rsse_pkg::*;
(
    input  wire logic        i_clock,    // core clock, 20 MHz
    input  wire logic        i_resetn,   // async reset, active low
    input  wire logic        i_psel,     // apb select
    input  wire logic        i_penable,  // apb access phase
    input  wire logic        i_pwrite,   // apb direction
    input  wire logic [7:0]  i_paddr,    // apb byte address
    input  wire logic [31:0] i_pwdata,   // apb write data
    input  wire logic        i_wake,     // wake event, ends halt
    output logic      [31:0] o_prdata,   // apb read data
    output logic             o_pready,   // apb ready
    output logic             o_pslverr,  // apb error, unmapped address
    output logic             o_osc_run,  // main oscillator running
    output logic             o_sleeping  // halt state
);
    rsse_mem_if mem ();

    rsse_file_ram u_ram (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .bus      (mem.mem)
    );

    function automatic logic [8:0] rot_thru_carry(input logic [7:0] v, input logic c, input logic left);
        if (left)
            rot_thru_carry = {v[7], v[6:0], c};
        else
            rot_thru_carry = {v[0], c, v[7:1]};
    endfunction : rot_thru_carry

    rsse_state_t state_q, state_d;
    logic [7:0]  w_q, w_d;
    logic        c_q, c_d, dc_q, dc_d, z_q, z_d, to_q, to_d, pd_q, pd_d;
    logic [7:0]  wdog_q, wdog_d, presc_q, presc_d;
    logic [6:0]  faddr_q, faddr_d, cmd_fa_q, cmd_fa_d;
    logic        cmd_left_q, cmd_left_d, cmd_dest_q, cmd_dest_d;
    logic [31:0] prdata_q, prdata_d;
    logic        rdok_q, rdok_d, memok_q, memok_d;

    logic        busy, mapped, acc, wr_acc, cmd_go, sub_go, sleep_go, faddr_wr;
    rsse_op_t    op;
    logic [7:0]  lit, sub_res, exec_res;
    logic [8:0]  rot;
    logic        exec_rot;

    assign busy     = state_q == RSSE_FETCH || state_q == RSSE_EXEC;
    assign mapped   = i_paddr inside {RSSE_OFF_CMD, RSSE_OFF_WREG, RSSE_OFF_STATUS,
                                      RSSE_OFF_WDOG, RSSE_OFF_FADDR, RSSE_OFF_FDATA};
    assign o_pready = i_psel && i_penable && rdok_q && !busy;
    assign o_pslverr = o_pready && !mapped;
    assign acc      = o_pready;
    assign wr_acc   = acc && i_pwrite && mapped;
    assign op       = rsse_op_t'(i_pwdata[RSSE_CMD_OP_LSB +: 2]);
    assign lit      = i_pwdata[RSSE_CMD_LIT_LSB +: 8];
    // commands written while halted are dropped: execution has ceased
    assign cmd_go   = wr_acc && i_paddr == RSSE_OFF_CMD && state_q == RSSE_IDLE;
    assign sub_go   = cmd_go && op == RSSE_OP_SUB;
    assign sleep_go = cmd_go && op == RSSE_OP_SLEEP;
    assign faddr_wr = wr_acc && i_paddr == RSSE_OFF_FADDR;
    assign sub_res  = lit - w_q;
    assign exec_rot = state_q == RSSE_EXEC;
    assign rot      = rot_thru_carry(mem.rdata, c_q, cmd_left_q);
    assign exec_res = rot[7:0];

    // file port: the command owns it while fetching/executing
    always_comb
    begin
        mem.addr  = busy ? cmd_fa_q : faddr_q;
        mem.we    = (exec_rot && cmd_dest_q) || (wr_acc && i_paddr == RSSE_OFF_FDATA);
        mem.wdata = exec_rot ? exec_res : i_pwdata[7:0];
    end

    always_comb
    begin
        state_d    = state_q;
        w_d        = w_q;
        c_d        = c_q;
        dc_d       = dc_q;
        z_d        = z_q;
        to_d       = to_q;
        pd_d       = pd_q;
        cmd_fa_d   = cmd_fa_q;
        cmd_left_d = cmd_left_q;
        cmd_dest_d = cmd_dest_q;
        faddr_d    = faddr_wr ? i_pwdata[RSSE_FA_W-1:0] : faddr_q;
        // watchdog keeps its own time base, so it runs during halt too
        presc_d    = presc_q + 8'h01;
        wdog_d     = (presc_q == 8'hff) ? wdog_q + 8'h01 : wdog_q;
        if (wr_acc && i_paddr == RSSE_OFF_WREG)
            w_d = i_pwdata[7:0];
        if (wr_acc && i_paddr == RSSE_OFF_STATUS)
        begin
            c_d  = i_pwdata[RSSE_ST_CARRY];
            dc_d = i_pwdata[RSSE_ST_DC];
            z_d  = i_pwdata[RSSE_ST_ZERO];
        end
        unique case (state_q)
            RSSE_IDLE:
            begin
                if (cmd_go && (op == RSSE_OP_ROTL || op == RSSE_OP_ROTR))
                begin
                    cmd_fa_d   = i_pwdata[RSSE_CMD_FA_LSB +: RSSE_FA_W];
                    cmd_left_d = op == RSSE_OP_ROTL;
                    cmd_dest_d = i_pwdata[RSSE_CMD_DEST];
                    state_d    = RSSE_FETCH;
                end
                if (sub_go)
                begin
                    w_d  = sub_res;
                    c_d  = w_q <= lit;
                    dc_d = w_q[3:0] <= lit[3:0];
                    z_d  = sub_res == 8'h00;
                end
                if (sleep_go)
                begin
                    wdog_d  = 8'h00;
                    presc_d = 8'h00;
                    to_d    = 1'b1;
                    pd_d    = 1'b0;
                    state_d = RSSE_HALT;
                end
            end
            RSSE_FETCH:
                state_d = RSSE_EXEC;
            RSSE_EXEC:
            begin
                c_d = rot[8];
                if (!cmd_dest_q)
                    w_d = exec_res;
                state_d = RSSE_IDLE;
            end
            RSSE_HALT:
                if (i_wake)
                    state_d = RSSE_IDLE;
            default:
                state_d = RSSE_IDLE;
        endcase
    end

    // read data is sampled a cycle ahead; rdok says the sample is usable
    always_comb
    begin
        prdata_d = 32'h0000_0000;
        unique case (i_paddr)
            RSSE_OFF_CMD:    prdata_d = 32'h0000_0000;
            RSSE_OFF_WREG:   prdata_d = {24'h00_0000, w_q};
            RSSE_OFF_STATUS: prdata_d = {26'h000_0000, state_q == RSSE_HALT, to_q, pd_q, z_q, dc_q, c_q};
            RSSE_OFF_WDOG:   prdata_d = {16'h0000, wdog_q, presc_q};
            RSSE_OFF_FADDR:  prdata_d = {25'h000_0000, faddr_q};
            RSSE_OFF_FDATA:  prdata_d = {24'h00_0000, mem.rdata};
            default:         prdata_d = 32'h0000_0000;
        endcase
        memok_d = !busy && !mem.we && !faddr_wr;
        rdok_d  = i_psel && !busy && (i_paddr != RSSE_OFF_FDATA || memok_q);
    end

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_q    <= RSSE_IDLE;
            w_q        <= RSSE_W_RST;
            c_q        <= 1'b0;
            dc_q       <= 1'b0;
            z_q        <= 1'b0;
            to_q       <= RSSE_TO_RST;
            pd_q       <= RSSE_PD_RST;
            wdog_q     <= 8'h00;
            presc_q    <= 8'h00;
            faddr_q    <= 7'h00;
            cmd_fa_q   <= 7'h00;
            cmd_left_q <= 1'b0;
            cmd_dest_q <= 1'b0;
            prdata_q   <= 32'h0000_0000;
            rdok_q     <= 1'b0;
            memok_q    <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            w_q        <= w_d;
            c_q        <= c_d;
            dc_q       <= dc_d;
            z_q        <= z_d;
            to_q       <= to_d;
            pd_q       <= pd_d;
            wdog_q     <= wdog_d;
            presc_q    <= presc_d;
            faddr_q    <= faddr_d;
            cmd_fa_q   <= cmd_fa_d;
            cmd_left_q <= cmd_left_d;
            cmd_dest_q <= cmd_dest_d;
            prdata_q   <= prdata_d;
            rdok_q     <= rdok_d;
            memok_q    <= memok_d;
        end
    end

    assign o_prdata   = prdata_q;
    assign o_osc_run  = state_q != RSSE_HALT;
    assign o_sleeping = state_q == RSSE_HALT;

    // checks
    sequence s_halt_entry;
        sleep_go ##1 (state_q == RSSE_HALT);
    endsequence

    a_rotl_shift: assert property (@(posedge i_clock) disable iff (!i_resetn)
        exec_rot && cmd_left_q |=> c_q == $past(mem.rdata[7]) && dc_q == $past(dc_q) && z_q == $past(z_q)
            && $past(exec_res) == {$past(mem.rdata[6:0]), $past(c_q)})
        else $error("rotate left result or carry wrong");
    a_rotr_shift: assert property (@(posedge i_clock) disable iff (!i_resetn)
        exec_rot && !cmd_left_q |=> c_q == $past(mem.rdata[0]) && dc_q == $past(dc_q) && z_q == $past(z_q)
            && $past(exec_res) == {$past(c_q), $past(mem.rdata[7:1])})
        else $error("rotate right result or carry wrong");
    a_rot_to_w: assert property (@(posedge i_clock) disable iff (!i_resetn)
        exec_rot && !cmd_dest_q |-> !mem.we ##1 w_q == $past(exec_res))
        else $error("rotate to working register wrong");
    a_rot_to_file: assert property (@(posedge i_clock) disable iff (!i_resetn)
        exec_rot && cmd_dest_q |-> mem.we && mem.wdata == exec_res && mem.addr == cmd_fa_q ##1 w_q == $past(w_q))
        else $error("rotate to file register wrong");
    a_halt_clears: assert property (@(posedge i_clock) disable iff (!i_resetn)
        s_halt_entry |-> wdog_q == 8'h00 && presc_q == 8'h00 && to_q && !pd_q)
        else $error("halt entry did not clear watchdog or set status");
    a_halt_stays: assert property (@(posedge i_clock) disable iff (!i_resetn)
        state_q == RSSE_HALT && !i_wake |=> state_q == RSSE_HALT && !o_osc_run && !$changed(w_q))
        else $error("halt left without wake");
    a_sub_value: assert property (@(posedge i_clock) disable iff (!i_resetn)
        sub_go |=> w_q == 8'($past(lit) - $past(w_q)) && c_q == ($past(w_q) <= $past(lit)))
        else $error("literal minus working result or carry wrong");
    a_sub_dcarry: assert property (@(posedge i_clock) disable iff (!i_resetn)
        sub_go && w_q[3:0] > lit[3:0] |=> !dc_q)
        else $error("digit carry not cleared on nibble borrow");
    a_sub_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
        sub_go |=> z_q == (w_q == 8'h00) && dc_q == ($past(w_q[3:0]) <= $past(lit[3:0])))
        else $error("zero or digit carry wrong after subtract");
endmodule : rsse_exec
`default_nettype wire

// File: tb/rsse_apb_model.sv
// rsse_apb_model: apb master standing in for the instruction decoder.
// assumes one core clock; bus signals change only just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module rsse_apb_model
(
    input  wire logic        i_clock,   // core clock
    input  wire logic [31:0] i_prdata,  // read data
    input  wire logic        i_pready,  // ready
    input  wire logic        i_pslverr, // error
    output logic             o_psel,    // select
    output logic             o_penable, // access phase
    output logic             o_pwrite,  // direction
    output logic      [7:0]  o_paddr,   // byte address
    output logic      [31:0] o_pwdata   // write data
);
    initial
    begin
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_pwrite  = 1'b0;
        o_paddr   = 8'h00;
        o_pwdata  = 32'h0;
    end

    // no fixed latency assumed: only the bench watchdog ends a stuck wait
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rdata, output logic err);
        @(posedge i_clock);
        o_psel    <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite  <= wr;
        o_paddr   <= a;
        o_pwdata  <= d;
        @(posedge i_clock);
        o_penable <= 1'b1;
        do
            @(posedge i_clock);
        while (i_pready !== 1'b1);
        rdata = i_prdata;
        err   = i_pslverr;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
        // released bus shows no stale address or data
        o_paddr   <= ~a;
        o_pwdata  <= ~d;
    endtask : xfer
endmodule : rsse_apb_model
`default_nettype wire

// File: tb/tb_top.sv
// tb_top: self-checking bench for the rotate/subtract/halt datapath.
// assumes rsse_exec is the top and its registers sit on apb.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import rsse_pkg::*;
;
    logic        i_clock;
    logic        i_resetn;
    logic        i_wake;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic        osc_run;
    logic        sleeping;
    logic        err;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    int          bad_count;
    int          comparisons;
    logic [15:0] sub_cases [7] = '{16'h0505, 16'h0305, 16'h2001, 16'hff00, 16'h0001, 16'h1523, 16'h100f};

    rsse_exec rsse_exec_inst (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_wake(i_wake), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_osc_run(osc_run), .o_sleeping(sleeping));
    rsse_apb_model rsse_apb_model_inst (.i_clock(i_clock), .i_prdata(prdata), .i_pready(pready),
        .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
        .o_pwdata(pwdata));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        rsse_apb_model_inst.xfer(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        rsse_apb_model_inst.xfer(1'b0, a, 32'h0, rd, err);
    endtask : rdr

    task automatic test_reset;
        rdr(RSSE_OFF_STATUS);
        chk("status", 32'h18, rd);
        chk("mapped err", 32'h0, {31'h0, err});
        rdr(8'h18);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        wr(8'h1c, 32'hffff_ffff);
        chk("unmapped werr", 32'h1, {31'h0, err});
        $display("test reset done");
    endtask : test_reset

    task automatic test_rotate;
        logic [7:0] v;
        logic [7:0] res;
        logic [6:0] fa;
        logic [2:0] st;
        logic       cout;
        for (int i = 0; i < 8; i++)
        begin
            v    = i[2] ? 8'h35 : 8'he6;
            fa   = i[0] ? 7'h7f : 7'h01;
            st   = {i[1], ~i[1], i[2]};
            res  = i[0] ? {st[0], v[7:1]} : {v[6:0], st[0]};
            cout = i[0] ? v[0] : v[7];
            wr(RSSE_OFF_FADDR, {25'h0, fa});
            wr(RSSE_OFF_FDATA, {24'h0, v});
            wr(RSSE_OFF_WREG, 32'h5a);
            wr(RSSE_OFF_STATUS, {29'h0, st});
            wr(RSSE_OFF_CMD, {16'h0, 1'b0, fa, 5'h0, i[1], 1'b0, i[0]});
            rdr(RSSE_OFF_WREG);
            chk("w", {24'h0, i[1] ? 8'h5a : res}, rd);
            rdr(RSSE_OFF_FDATA);
            chk("file", {24'h0, i[1] ? res : v}, rd);
            rdr(RSSE_OFF_STATUS);
            chk("status", {29'h3, st[2:1], cout}, rd);
        end
        $display("test rotate done");
    endtask : test_rotate

    task automatic test_sub;
        logic [7:0] k;
        logic [7:0] w;
        logic [7:0] r;
        logic [2:0] fl;
        for (int i = 0; i < 7; i++)
        begin
            k  = sub_cases[i][15:8];
            w  = sub_cases[i][7:0];
            r  = k - w;
            fl = {r == 8'h00, w[3:0] <= k[3:0], w <= k};
            wr(RSSE_OFF_WREG, {24'h0, w});
            wr(RSSE_OFF_STATUS, {29'h0, ~fl});
            wr(RSSE_OFF_CMD, {8'h0, k, 16'h2});
            rdr(RSSE_OFF_WREG);
            chk("w", {24'h0, r}, rd);
            rdr(RSSE_OFF_STATUS);
            chk("status", {29'h3, fl}, rd);
        end
        $display("test sub done");
    endtask : test_sub

    task automatic test_sleep;
        logic [31:0] w0;
        repeat (300) @(posedge i_clock);
        rdr(RSSE_OFF_WDOG);
        chk("wdog running", 32'h1, {31'h0, rd[15:8] != 8'h00});
        wr(RSSE_OFF_CMD, 32'h3);
        @(posedge i_clock);
        #1;
        chk("sleeping", 32'h1, {31'h0, sleeping});
        chk("osc", 32'h0, {31'h0, osc_run});
        rdr(RSSE_OFF_WDOG);
        chk("wdog cleared", 32'h1, {31'h0, rd[15:0] < 16'h0010});
        rdr(RSSE_OFF_STATUS);
        chk("halt status", 32'h6, {29'h0, rd[5:3]});
        rdr(RSSE_OFF_WREG);
        w0 = rd;
        wr(RSSE_OFF_CMD, {8'h0, 8'h77, 16'h2});
        rdr(RSSE_OFF_WREG);
        chk("w halted", w0, rd);
        chk("still asleep", 32'h1, {31'h0, sleeping});
        @(posedge i_clock);
        i_wake <= 1'b1;
        @(posedge i_clock);
        i_wake <= 1'b0;
        repeat (2) @(posedge i_clock);
        #1;
        chk("awake osc", 32'h1, {31'h0, osc_run});
        $display("test sleep done");
    endtask : test_sleep

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    initial
    begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    // about fifteen times the expected run
    initial
    begin
        #500_000;
        bad_count++;
        finish_test();
    end

    initial
    begin
        i_resetn    = 1'b0;
        i_wake      = 1'b0;
        bad_count   = 0;
        comparisons = 0;
        repeat (16) @(posedge i_clock);
        i_resetn <= 1'b1;
        test_reset();
        test_rotate();
        test_sub();
        test_sleep();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
